// >>> verilog/tea_event_action.sv
// Top: event action decode, cycle event point and shared irq enables over APB
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Cycle point field at bits 7:6
// - Codes begin, end, between, boundary
// - Event one action field at 5:3
// - Ev1: off, direction, stop, decrement
// - Ev1: period/width capture channel order
// - Action one starts or restarts counter
// - Event zero action field at 2:0
// - Ev0: count, start, increment
// - Ev0 level count, 6 reserved, 7 fault
// - Clear register: zero writes change nothing
// - Clear register: one clears enable
// - Set and clear share enables
// - Clear register reads enable state
// - Bits 19:16 channel match enables
// - Bits 15:11 fault and debug enables
// - Bits 3:0 err, cycle, restart, wrap
// - Cycle event at chosen point
// - Inputs act only when enabled
// - Set register: one sets enable
module tea_event_action
  import tea_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire tea_pkg::tea_apb_req_t APB_REQ,
  output var  tea_pkg::tea_apb_rsp_t APB_RSP,
  input  wire logic                  EVENT_IN_ZERO,
  input  wire logic                  EVENT_IN_ONE,
  input  wire tea_pkg::tea_cyc_t     CYCLE_IN,
  input  wire logic [31:0]           IRQ_FLAG_SET,
  output var  tea_pkg::tea_cmd_t     CMD,
  output var  logic                  CYCLE_EVENT_OUT,
  output var  logic                  CYCLE_IRQ_POINT,
  output var  logic                  IRQ
);
  import tea_pkg::*;

  typedef struct packed {
    logic [31:0] evctrl;
    logic [31:0] irq_en;
    logic [31:0] irq_flag;
    logic        ev0_lvl;
    logic        ev1_lvl;
    logic        between;
    logic        cyc_evt;
    logic        cyc_point;
    tea_cmd_t    cmd;
    logic        irq;
    logic [31:0] prdata;
    logic        pslverr;
    logic        reserved_seen;
  } tea_st_t;

  tea_st_t st_q;
  tea_st_t st_d;
  logic    ev0_sync;
  logic    ev1_sync;
  logic    ev0_rise;
  logic    ev1_rise;
  logic    apb_wr;
  logic    apb_rd;
  logic    addr_ok;
  logic    cyc_hit;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] act_field(input logic [31:0] ctrl, input int pos);
    act_field = ctrl[pos +: 3];
  endfunction : act_field

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == OFF_EVENT_CTRL) || (a == OFF_IRQ_EN_CLEAR) ||
                 (a == OFF_IRQ_EN_SET) || (a == OFF_IRQ_FLAG) ||
                 (a == OFF_EVENT_STATUS);
  endfunction : known_addr

  // ----------------------------------------------------------------
  // Event pins
  // ----------------------------------------------------------------
  tea_sync u_sync0 (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .async_in  (EVENT_IN_ZERO),
    .level_out (ev0_sync)
  );

  tea_sync u_sync1 (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .async_in  (EVENT_IN_ONE),
    .level_out (ev1_sync)
  );

  assign ev0_rise = ev0_sync && !st_q.ev0_lvl;
  assign ev1_rise = ev1_sync && !st_q.ev1_lvl;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign apb_wr  = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign apb_rd  = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
  assign addr_ok = known_addr(APB_REQ.paddr);

  // ----------------------------------------------------------------
  // Cycle point decode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (tea_cycle_point_t'(st_q.evctrl[POS_CYCLE_POINT +: 2]))
      CP_BEGIN:    cyc_hit = CYCLE_IN.cycle_begin;
      CP_END:      cyc_hit = CYCLE_IN.cycle_end;
      CP_BETWEEN:  cyc_hit = st_q.between && CYCLE_IN.cycle_begin;
      CP_BOUNDARY: cyc_hit = CYCLE_IN.cycle_end ||
                             (CYCLE_IN.cycle_begin && CYCLE_IN.first_cycle);
      default:     cyc_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0]  act0;
    logic [2:0]  act1;
    logic        en0;
    logic        en1;
    logic [31:0] wdat;
    act0 = act_field(st_q.evctrl, POS_EV0_ACTION);
    act1 = act_field(st_q.evctrl, POS_EV1_ACTION);
    en0  = st_q.evctrl[POS_EV_IN_EN0];
    en1  = st_q.evctrl[POS_EV_IN_EN1];
    wdat = APB_REQ.pwdata;

    st_d         = st_q;
    st_d.ev0_lvl = ev0_sync;
    st_d.ev1_lvl = ev1_sync;
    st_d.cmd     = '0;
    // Direction and level-count follow the pins, not one-shot
    st_d.cmd.dir_down    = st_q.cmd.dir_down;
    st_d.cmd.count_level = 1'b0;

    // Between: gap after an end, closed by the next begin
    if (CYCLE_IN.cycle_end)
    begin
      st_d.between = 1'b1;
    end
    else if (CYCLE_IN.cycle_begin)
    begin
      st_d.between = 1'b0;
    end

    st_d.cyc_evt   = cyc_hit && st_q.evctrl[POS_CYCLE_EO_EN];
    st_d.cyc_point = cyc_hit;

    if (en0)
    begin
      case (act0)
        ACT_RETRIGGER: st_d.cmd.retrigger   = ev0_rise; // restart
        ACT0_COUNT:    st_d.cmd.count       = ev0_rise;
        ACT0_START:    st_d.cmd.start       = ev0_rise;
        ACT0_INC:      st_d.cmd.inc         = ev0_rise;
        ACT0_LEVEL:    st_d.cmd.count_level = ev0_sync;
        ACT_FAULT:     st_d.cmd.fault       = ev0_rise;
        // Reserved code acts as off, but is reported
        default:       st_d.reserved_seen   = st_q.reserved_seen || (act0 == 3'h6);
      endcase
    end

    if (en1)
    begin
      case (act1)
        ACT_RETRIGGER: st_d.cmd.retrigger = st_d.cmd.retrigger || ev1_rise; // restart
        ACT1_DIR:      st_d.cmd.dir_down  = ev1_sync;
        ACT1_STOP:     st_d.cmd.stop      = ev1_rise;
        ACT1_DEC:      st_d.cmd.dec       = ev1_rise;
        ACT1_PPW:      st_d.cmd.cap_ppw   = ev1_rise;
        ACT1_PWP:      st_d.cmd.cap_pwp   = ev1_rise;
        ACT_FAULT:     st_d.cmd.fault     = st_d.cmd.fault || ev1_rise;
        default:       st_d.cmd.stop      = 1'b0;
      endcase
    end

    // Flags: hardware set wins over software clear
    st_d.irq_flag = st_q.irq_flag;
    if (apb_wr && APB_REQ.paddr == OFF_IRQ_FLAG)
    begin
      st_d.irq_flag = st_q.irq_flag & ~wdat;
    end
    st_d.irq_flag = (st_d.irq_flag | IRQ_FLAG_SET) & IRQ_EN_MASK;

    if (apb_wr)
    begin
      case (APB_REQ.paddr)
        OFF_EVENT_CTRL:   st_d.evctrl = wdat & EVCTRL_MASK;
        OFF_IRQ_EN_CLEAR: st_d.irq_en = st_q.irq_en & ~(wdat & IRQ_EN_MASK);
        OFF_IRQ_EN_SET:   st_d.irq_en = st_q.irq_en | (wdat & IRQ_EN_MASK);
        // A new sighting in the clear cycle is kept
        OFF_EVENT_STATUS: st_d.reserved_seen = (st_q.reserved_seen && !wdat[0]) ||
                                               (en0 && act0 == 3'h6);
        default:          st_d.irq_en = st_q.irq_en;
      endcase
    end

    // Read data captured in setup, held through the access phase
    st_d.pslverr = APB_REQ.psel && !APB_REQ.penable && !addr_ok;
    if (apb_rd)
    begin
      case (APB_REQ.paddr)
        OFF_EVENT_CTRL:   st_d.prdata = st_q.evctrl;
        OFF_IRQ_EN_CLEAR: st_d.prdata = st_q.irq_en & IRQ_EN_MASK;
        OFF_IRQ_EN_SET:   st_d.prdata = st_q.irq_en & IRQ_EN_MASK;
        OFF_IRQ_FLAG:     st_d.prdata = st_q.irq_flag;
        OFF_EVENT_STATUS: st_d.prdata = {30'h0, st_q.reserved_seen, st_q.between};
        default:          st_d.prdata = APB_ERR_DATA;
      endcase
    end

    st_d.irq = |(st_d.irq_flag & st_d.irq_en);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q          <= '0;
      st_q.evctrl   <= RST_EVENT_CTRL;
      st_q.irq_en   <= RST_IRQ_EN;
      st_q.irq_flag <= RST_IRQ_FLAG;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states, so ready is a constant
  assign APB_RSP = '{pready:  1'b1,
                     pslverr: st_q.pslverr && APB_REQ.psel && APB_REQ.penable,
                     prdata:  st_q.prdata};
  assign CMD             = st_q.cmd;
  assign CYCLE_EVENT_OUT = st_q.cyc_evt;
  assign CYCLE_IRQ_POINT = st_q.cyc_point;
  assign IRQ             = st_q.irq;
endmodule : tea_event_action
`default_nettype wire

// >>> verilog/tea_pkg.sv
// Package: register map, field layout and codes of the event and irq-enable block
package tea_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_EVENT_CTRL   = 12'h020;
  localparam logic [11:0] OFF_IRQ_EN_CLEAR = 12'h024;
  localparam logic [11:0] OFF_IRQ_EN_SET   = 12'h028;
  localparam logic [11:0] OFF_IRQ_FLAG     = 12'h02C;
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h030;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_CYCLE_POINT  = 6;
  localparam int POS_EV1_ACTION   = 3;
  localparam int POS_EV0_ACTION   = 0;
  localparam int POS_CYCLE_EO_EN  = 10;
  localparam int POS_EV_IN_EN0    = 14;
  localparam int POS_EV_IN_EN1    = 15;
  localparam logic [31:0] RST_EVENT_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_EN     = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_FLAG   = 32'h0000_0000;
  // Implemented enable bits: channels 19:16, faults 15:11, err/cnt/trg/wrap 3:0
  localparam logic [31:0] IRQ_EN_MASK    = 32'h000F_F80F;
  localparam logic [31:0] EVCTRL_MASK    = 32'h0000_C4FF;
  localparam logic [31:0] APB_ERR_DATA   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CP_BEGIN    = 2'h0,
    CP_END      = 2'h1,
    CP_BETWEEN  = 2'h2,
    CP_BOUNDARY = 2'h3
  } tea_cycle_point_t;

  localparam logic [2:0] ACT_OFF       = 3'h0;
  localparam logic [2:0] ACT_RETRIGGER = 3'h1;
  localparam logic [2:0] ACT1_DIR      = 3'h2;
  localparam logic [2:0] ACT1_STOP     = 3'h3;
  localparam logic [2:0] ACT1_DEC      = 3'h4;
  localparam logic [2:0] ACT1_PPW      = 3'h5;
  localparam logic [2:0] ACT1_PWP      = 3'h6;
  localparam logic [2:0] ACT0_COUNT    = 3'h2;
  localparam logic [2:0] ACT0_START    = 3'h3;
  localparam logic [2:0] ACT0_INC      = 3'h4;
  localparam logic [2:0] ACT0_LEVEL    = 3'h5;
  localparam logic [2:0] ACT_FAULT     = 3'h7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tea_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tea_apb_rsp_t;

  // Counter-core commands, one-cycle pulses except the levels noted
  typedef struct packed {
    logic retrigger;
    logic stop;
    logic start;
    logic count;
    logic inc;
    logic dec;
    logic dir_down;
    logic count_level;
    logic cap_ppw;
    logic cap_pwp;
    logic fault;
  } tea_cmd_t;

  typedef struct packed {
    logic cycle_begin;
    logic cycle_end;
    logic first_cycle;
  } tea_cyc_t;

endpackage : tea_pkg

// >>> verilog/tea_sync.sv
// Three-stage synchroniser with agreement filter for event pins
`timescale 1ns/100ps
`default_nettype none
module tea_sync (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic async_in,
  output var  logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tea_sync_st_t;

  tea_sync_st_t st_q;
  tea_sync_st_t st_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Level moves only once stages two and three agree
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule : tea_sync
`default_nettype wire

// >>> verification/tea_monitor.sv
// Checker of bus, event and irq relations at the top ports
`timescale 1ns/100ps
`default_nettype none
module tea_monitor
  import tea_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  RST_N,
  input wire tea_pkg::tea_apb_req_t APB_REQ,
  input wire tea_pkg::tea_apb_rsp_t APB_RSP,
  input wire tea_pkg::tea_cyc_t     CYCLE_IN,
  input wire logic [31:0]           IRQ_FLAG_SET,
  input wire tea_pkg::tea_cmd_t     CMD,
  input wire logic                  CYCLE_EVENT_OUT,
  input wire logic                  CYCLE_IRQ_POINT,
  input wire logic                  IRQ
);
  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic acc = APB_REQ.psel && APB_REQ.penable;
  wire logic wr  = acc && APB_REQ.pwrite;
  sequence s_clr_all;
    wr && APB_REQ.paddr == OFF_IRQ_EN_CLEAR && APB_REQ.pwdata == 32'hFFFFFFFF;
  endsequence
  // Enable and irq register both update on the first edge; checked at the second
  sequence s_irq_quiet;
    ##2 !IRQ;
  endsequence
  property p_clr_all;
    s_clr_all |-> s_irq_quiet;
  endproperty
  property p_irq_cause;
    $rose(IRQ) |-> $past(|IRQ_FLAG_SET) || $past(wr);
  endproperty
  property p_point_cause;
    CYCLE_IRQ_POINT |-> $past(CYCLE_IN.cycle_begin) || $past(CYCLE_IN.cycle_end);
  endproperty
  property p_evt_point;
    CYCLE_EVENT_OUT |-> CYCLE_IRQ_POINT;
  endproperty
  property p_slverr;
    APB_RSP.pslverr |-> acc;
  endproperty
  property p_err_data;
    acc && !APB_REQ.pwrite && APB_RSP.pslverr |-> APB_RSP.prdata == APB_ERR_DATA;
  endproperty
  property p_retrig;
    CMD.retrigger |=> !CMD.retrigger;
  endproperty
  property p_cap;
    !(CMD.cap_ppw && CMD.cap_pwp);
  endproperty
  property p_inc;
    CMD.inc |=> !CMD.inc;
  endproperty
  property p_stop;
    CMD.stop |=> !CMD.stop;
  endproperty
  a_clr_all: assert property (p_clr_all)
    else $error("irq still high after clearing all enables");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without flag or write");
  a_point_cause: assert property (p_point_cause)
    else $error("cycle point without core pulse");
  a_evt_point: assert property (p_evt_point)
    else $error("cycle event off the chosen point");
  a_slverr: assert property (p_slverr)
    else $error("slave error outside access phase");
  a_err_data: assert property (p_err_data)
    else $error("refused read returned data");
  a_retrig: assert property (p_retrig)
    else $error("retrigger longer than one cycle");
  a_cap: assert property (p_cap)
    else $error("both capture orders at once");
  a_inc: assert property (p_inc)
    else $error("increment longer than one cycle");
  a_stop: assert property (p_stop)
    else $error("stop longer than one cycle");
endmodule : tea_monitor
bind tea_event_action tea_monitor u_mon (
  .CLK(CLK), .RST_N(RST_N), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
  .CYCLE_IN(CYCLE_IN), .IRQ_FLAG_SET(IRQ_FLAG_SET), .CMD(CMD),
  .CYCLE_EVENT_OUT(CYCLE_EVENT_OUT), .CYCLE_IRQ_POINT(CYCLE_IRQ_POINT), .IRQ(IRQ)
);
`default_nettype wire

// >>> verification/tea_partner.sv
// Model of the event router and counter core
`timescale 1ns/100ps
`default_nettype none
module tea_partner
  import tea_pkg::*;
(
  input  wire logic              clk,
  output var  logic              ev_zero,
  output var  logic              ev_one,
  output var  tea_pkg::tea_cyc_t cyc
);
  initial
  begin
    ev_zero = 1'b0;
    ev_one  = 1'b0;
    cyc     = '0;
  end
  // Held four cycles, past the pin filter
  task automatic ev(input logic which);
    @(posedge clk);
    if (which) ev_one <= 1'b1;
    else ev_zero <= 1'b1;
    repeat (4) @(posedge clk);
    ev_zero <= 1'b0;
    ev_one  <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : ev
  task automatic pulse(input tea_cyc_t v);
    @(posedge clk);
    cyc <= v;
    @(posedge clk);
    cyc <= '0;
  endtask : pulse
endmodule : tea_partner
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the event action and irq enable block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tea_pkg::*;
  logic         CLK;
  logic         RST_N;
  tea_apb_req_t req;
  tea_apb_rsp_t rsp;
  logic [31:0]  flg;
  tea_cyc_t     cyc;
  tea_cmd_t     cmd;
  logic         ev0;
  logic         ev1;
  logic         ceo;
  logic         cip;
  logic         irq;
  logic [31:0]  rd;
  logic         er;
  int           n_fail = 0;
  int           tests_run = 0;
  tea_event_action uut (.CLK(CLK), .RST_N(RST_N), .APB_REQ(req), .APB_RSP(rsp),
    .EVENT_IN_ZERO(ev0), .EVENT_IN_ONE(ev1), .CYCLE_IN(cyc), .IRQ_FLAG_SET(flg),
    .CMD(cmd), .CYCLE_EVENT_OUT(ceo), .CYCLE_IRQ_POINT(cip), .IRQ(irq));
  tea_partner pm (.clk(CLK), .ev_zero(ev0), .ev_one(ev1), .cyc(cyc));
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Waits on pready only; the watchdog ends a hang
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge CLK);
    req.penable <= 1'b1;
    do @(posedge CLK); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : bus
  task automatic watch(input logic w, output tea_cmd_t a);
    a = '0;
    fork
      pm.ev(w);
      repeat (14)
      begin
        @(posedge CLK);
        a = a | cmd;
      end
    join
  endtask : watch
  function automatic tea_cmd_t exp_cmd(input logic [3:0] k);
    tea_cmd_t e;
    e = '0;
    case (k)
      4'h1, 4'h9: e.retrigger = 1'b1;
      4'h2: e.count = 1'b1;
      4'h3: e.start = 1'b1;
      4'h4: e.inc = 1'b1;
      4'h5: e.count_level = 1'b1;
      4'h7, 4'hF: e.fault = 1'b1;
      4'hA: e.dir_down = 1'b1;
      4'hB: e.stop = 1'b1;
      4'hC: e.dec = 1'b1;
      4'hD: e.cap_ppw = 1'b1;
      4'hE: e.cap_pwp = 1'b1;
      default: e = '0;
    endcase
    return e;
  endfunction : exp_cmd
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_regs;
    bus(0, OFF_IRQ_EN_CLEAR, 32'h0);
    chk("clr_reset", rd, 32'h0);
    bus(1, OFF_IRQ_EN_SET, 32'hFFFFFFFF);
    bus(0, OFF_IRQ_EN_CLEAR, 32'h0);
    chk("clr_all_on", rd, 32'h000FF80F);
    bus(1, OFF_IRQ_EN_CLEAR, 32'h0);
    bus(0, OFF_IRQ_EN_SET, 32'h0);
    chk("clr_zero", rd, 32'h000FF80F);
    bus(1, OFF_IRQ_EN_CLEAR, 32'h00010004);
    bus(0, OFF_IRQ_EN_SET, 32'h0);
    chk("clr_some", rd, 32'h000EF80B);
    bus(1, OFF_IRQ_EN_CLEAR, 32'h00088008);
    bus(0, OFF_IRQ_EN_CLEAR, 32'h0);
    chk("clr_edges", rd, 32'h00067803);
    bus(1, OFF_IRQ_EN_CLEAR, 32'hFFFFFFFF);
    bus(0, OFF_IRQ_EN_SET, 32'h0);
    chk("clr_all", rd, 32'h0);
    bus(0, 12'h100, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_irq;
    bus(1, OFF_IRQ_EN_SET, 32'h4);
    @(posedge CLK);
    flg <= 32'h5;
    @(posedge CLK);
    flg <= 32'h0;
    repeat (4) @(posedge CLK);
    chk("irq_on", {31'h0, irq}, 32'h1);
    bus(1, OFF_IRQ_EN_CLEAR, 32'h4);
    repeat (3) @(posedge CLK);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1, OFF_IRQ_EN_SET, 32'h1);
    repeat (3) @(posedge CLK);
    chk("irq_set", {31'h0, irq}, 32'h1);
    bus(0, OFF_IRQ_FLAG, 32'h0);
    chk("flag_held", rd, 32'h5);
    bus(1, OFF_IRQ_FLAG, 32'hFFFFFFFF);
    bus(0, OFF_IRQ_FLAG, 32'h0);
    chk("flag_clr", rd, 32'h0);
    bus(1, OFF_IRQ_EN_CLEAR, 32'hFFFFFFFF);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_act;
    tea_cmd_t    a;
    int          k;
    logic [31:0] wd;
    bus(1, OFF_EVENT_CTRL, 32'h9);
    watch(0, a);
    chk("ev0_off", {21'h0, a}, 32'h0);
    watch(1, a);
    chk("ev1_off", {21'h0, a}, 32'h0);
    // Direction row last: its level may be held afterwards
    for (int i = 0; i < 16; i++)
    begin
      k = (i == 15) ? 10 : ((i >= 10) ? i + 1 : i);
      wd = 32'h0000C000 | (32'(k[2:0]) << (k[3] ? POS_EV1_ACTION : POS_EV0_ACTION));
      bus(1, OFF_EVENT_CTRL, wd);
      bus(0, OFF_EVENT_CTRL, 32'h0);
      chk("evctrl", rd, wd);
      watch(k[3], a);
      chk("ev_action", {21'h0, a}, {21'h0, exp_cmd(k[3:0])});
    end
    bus(0, OFF_EVENT_STATUS, 32'h0);
    chk("reserved_seen", rd, 32'h2);
    bus(1, OFF_EVENT_STATUS, 32'h1);
    bus(0, OFF_EVENT_STATUS, 32'h0);
    chk("reserved_clr", rd, 32'h0);
    $display("t_act done");
  endtask : t_act
  task automatic t_cyc;
    logic [31:0] c1;
    logic [31:0] c2;
    int          ex [4] = '{3, 2, 2, 3};
    for (int cp = 0; cp < 5; cp++)
    begin
      bus(1, OFF_EVENT_CTRL, (cp < 4 ? 32'h400 : 32'h0) | (32'(cp & 3) << POS_CYCLE_POINT));
      c1 = '0;
      c2 = '0;
      fork
        begin
          pm.pulse(3'b101);
          pm.pulse(3'b010);
          pm.pulse(3'b100);
          pm.pulse(3'b010);
          pm.pulse(3'b100);
        end
        repeat (14)
        begin
          @(posedge CLK);
          c1 = c1 + ceo;
          c2 = c2 + cip;
        end
      join
      chk("cyc_event", c1, cp < 4 ? ex[cp] : 0);
      chk("cyc_point", c2, ex[cp & 3]);
    end
    $display("t_cyc done");
  endtask : t_cyc
  task automatic t_rst;
    bus(1, OFF_IRQ_EN_SET, 32'hFFFFFFFF);
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    bus(0, OFF_IRQ_EN_CLEAR, 32'h0);
    chk("rst_en", rd, 32'h0);
    chk("rst_irq", {31'h0, irq}, 32'h0);
    $display("t_rst done");
  endtask : t_rst
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    RST_N = 1'b0;
    req   = '0;
    flg   = '0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    t_regs();
    t_irq();
    t_act();
    t_cyc();
    t_rst();
    summarize();
  end
  // Run needs about 540 cycles
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
